// [common/irq_map_pkg.sv]
// constants, source layout and trigger encodings of the peripheral interrupt mapper
// -----------------------------------------------------------------------------
// How it works
// - host read of a core-to-host scratch byte sets its bit; OR drives line 35.
// - host write of a host-to-core scratch byte sets its bit; OR drives line 36.
// - channel 0 overflow and channels 1-3 underflow combine onto line 32.
// - serial master 0 done drives line 23, serial master 1 done line 24.
// - two-wire master 0 done drives line 25, two-wire master 1 done line 26.
// - flash port data and done requests merge onto line 33.
// - real-time counter overflow drives line 27.
// - interval timer reaching its limit drives line 28.
// - twelve pad event channels trigger per setup, combine onto event line 31.
// -----------------------------------------------------------------------------
package irq_map_pkg;

  // source positions inside the pending vector
  localparam int SRC_RD   = 0;   // 16 core-to-host scratch byte reads
  localparam int SRC_WR   = 16;  // 16 host-to-core scratch byte writes
  localparam int SRC_BUF  = 32;  // 4 host channel buffer errors
  localparam int SRC_SM0  = 36;
  localparam int SRC_SM1  = 37;
  localparam int SRC_TW0  = 38;
  localparam int SRC_TW1  = 39;
  localparam int SRC_QD   = 40;  // flash data request
  localparam int SRC_QF   = 41;  // flash done request
  localparam int SRC_RTC  = 42;
  localparam int SRC_ITM  = 43;
  localparam int SRC_UTM  = 44;
  localparam int SRC_PAD  = 45;  // 12 pad event channels
  localparam int SRC_SW   = 57;  // 4 software bits
  localparam int SRC_NUM  = 61;

  localparam int SCRATCH_NUM = 16;
  localparam int BUF_NUM     = 4;
  localparam int PAD_NUM     = 12;
  localparam int SW_NUM      = 4;

  // core interrupt line numbers
  localparam int IRQ_LO     = 23;
  localparam int IRQ_HI     = 40;
  localparam int IRQ_SM0    = 23;
  localparam int IRQ_SM1    = 24;
  localparam int IRQ_TW0    = 25;
  localparam int IRQ_TW1    = 26;
  localparam int IRQ_RTC    = 27;
  localparam int IRQ_ITM    = 28;
  localparam int IRQ_UTM    = 29;
  localparam int IRQ_PAD    = 31;
  localparam int IRQ_BUF    = 32;
  localparam int IRQ_FLASH  = 33;
  localparam int IRQ_RD     = 35;
  localparam int IRQ_WR     = 36;
  localparam int IRQ_SW     = 37;

  // lines classed as event interrupts (only the pad line)
  localparam logic [IRQ_HI:IRQ_LO] EVENT_CLASS_MASK = 18'h00100;
  localparam logic [SRC_NUM-1:0]   PEND_RESET       = '0;

  // pad channel trigger setup, gray ordered
  typedef enum logic [1:0] {
    TRIG_RISE = 2'h0,
    TRIG_FALL = 2'h1,
    TRIG_BOTH = 2'h3,
    TRIG_HIGH = 2'h2
  } pad_trig_t;

  // universal timer condition select; code 2 is unused
  typedef enum logic [1:0] {
    UTM_LIMIT   = 2'h0,
    UTM_COMPARE = 2'h1,
    UTM_CAPTURE = 2'h3
  } utmr_src_t;

endpackage : irq_map_pkg

// [core/pend_bank.sv]
// sticky pending flags with set-over-clear
`timescale 1ns/10ps
module pend_bank
  import irq_map_pkg::*;
#(
  parameter int W = SRC_NUM
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  // set and clear strobes
  input  wire logic [W-1:0] set_vec,
  input  wire logic [W-1:0] clr_vec,
  // flag state
  output logic      [W-1:0] pend_ff,
  output logic      [W-1:0] nxt_pend
);

  // ---------------------------------------------------------------------------
  // per-bit pending
  // ---------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // set beats a clear in the same cycle so no event is lost
      always_comb begin
        nxt_pend[i] = set_vec[i] | (pend_ff[i] & ~clr_vec[i]);
      end
    end
  endgenerate

  // register only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_ff <= PEND_RESET[W-1:0];
    end else begin
      pend_ff <= nxt_pend;
    end
  end

endmodule : pend_bank

// [core/periph_irq_mapper.sv]
// peripheral interrupt mapper: sticky sources grouped onto core interrupt lines
`timescale 1ns/10ps
module periph_irq_mapper
  import irq_map_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  // host interface scratch accesses
  input  wire logic                    host_read_access,
  input  wire logic [3:0]              host_read_sel,
  input  wire logic                    host_write_access,
  input  wire logic [3:0]              host_write_sel,
  // host channel buffer errors
  input  wire logic                    host_chan0_overflow_req,
  input  wire logic                    host_chan1_underflow_req,
  input  wire logic                    host_chan2_underflow_req,
  input  wire logic                    host_chan3_underflow_req,
  // master ports
  input  wire logic                    serial_master0_done_req,
  input  wire logic                    serial_master1_done_req,
  input  wire logic                    twowire_master0_done_req,
  input  wire logic                    twowire_master1_done_req,
  // flash port
  input  wire logic                    flash_data_req,
  input  wire logic                    flash_done_req,
  // timers
  input  wire logic                    rtc_overflow_req,
  input  wire logic                    itimer_limit_req,
  input  wire logic [1:0]              utimer_src_sel,
  input  wire logic                    utimer_limit_hit,
  input  wire logic                    utimer_compare_hit,
  input  wire logic                    utimer_capture_hit,
  // pad event channels
  input  wire logic [PAD_NUM-1:0]      pad_event_req,
  input  wire logic [2*PAD_NUM-1:0]    pad_trig_setup,
  // software requests
  input  wire logic [SW_NUM-1:0]       software_request_vec,
  // core side clear of pending sources
  input  wire logic [SRC_NUM-1:0]      core_clear_vec,
  // core interrupt lines and status
  output logic      [IRQ_HI:IRQ_LO]    core_irq_ff,
  output logic      [IRQ_HI:IRQ_LO]    event_class_ff,
  output logic      [SRC_NUM-1:0]      pend_ff
);

  // ---------------------------------------------------------------------------
  // pad channel trigger detection
  // ---------------------------------------------------------------------------
  logic [PAD_NUM-1:0] pad_prev_ff;
  logic [PAD_NUM-1:0] nxt_pad_prev;
  logic [PAD_NUM-1:0] pad_set;

  genvar c;
  generate
    for (c = 0; c < PAD_NUM; c++) begin : g_pad
      pad_trig_t mode;
      logic      rise;
      logic      fall;
      // level mode re-arms each cycle while high; edge modes fire once per edge
      always_comb begin
        mode     = pad_trig_t'(pad_trig_setup[2*c +: 2]);
        rise     = pad_event_req[c] & ~pad_prev_ff[c];
        fall     = ~pad_event_req[c] & pad_prev_ff[c];
        unique case (mode)
          TRIG_RISE: pad_set[c] = rise;
          TRIG_FALL: pad_set[c] = fall;
          TRIG_BOTH: pad_set[c] = rise | fall;
          TRIG_HIGH: pad_set[c] = pad_event_req[c];
        endcase
      end
    end
  endgenerate

  // previous pad level
  always_comb begin
    nxt_pad_prev = pad_event_req;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pad_prev_ff <= '0;
    end else begin
      pad_prev_ff <= nxt_pad_prev;
    end
  end

  // ---------------------------------------------------------------------------
  // source set vector
  // ---------------------------------------------------------------------------
  logic [SRC_NUM-1:0] set_vec;
  logic               utm_hit;
  logic [SRC_NUM-1:0] nxt_pend;

  // universal timer condition picked by its setup; unused code raises nothing
  always_comb begin
    unique case (utimer_src_sel)
      UTM_LIMIT:   utm_hit = utimer_limit_hit;
      UTM_COMPARE: utm_hit = utimer_compare_hit;
      UTM_CAPTURE: utm_hit = utimer_capture_hit;
      default:     utm_hit = 1'b0;
    endcase
  end

  always_comb begin
    set_vec = '0;
    set_vec[SRC_RD + host_read_sel]  = host_read_access;
    set_vec[SRC_WR + host_write_sel] = host_write_access;
    set_vec[SRC_BUF +: BUF_NUM]      = {host_chan3_underflow_req, host_chan2_underflow_req,
                                        host_chan1_underflow_req, host_chan0_overflow_req};
    set_vec[SRC_SM0] = serial_master0_done_req;
    set_vec[SRC_SM1] = serial_master1_done_req;
    set_vec[SRC_TW0] = twowire_master0_done_req;
    set_vec[SRC_TW1] = twowire_master1_done_req;
    set_vec[SRC_QD]  = flash_data_req;
    set_vec[SRC_QF]  = flash_done_req;
    set_vec[SRC_RTC] = rtc_overflow_req;
    set_vec[SRC_ITM] = itimer_limit_req;
    set_vec[SRC_UTM] = utm_hit;
    set_vec[SRC_PAD +: PAD_NUM] = pad_set;
    set_vec[SRC_SW +: SW_NUM]   = software_request_vec;
  end

  // sticky pending flags, cleared by the core
  pend_bank #(
    .W (SRC_NUM)
  ) u_pend (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .set_vec  (set_vec),
    .clr_vec  (core_clear_vec),
    .pend_ff  (pend_ff),
    .nxt_pend (nxt_pend)
  );

  // ---------------------------------------------------------------------------
  // line mapping
  // ---------------------------------------------------------------------------
  logic [IRQ_HI:IRQ_LO] nxt_irq;

  // lines follow the next pending state so line and flag change on the same edge
  always_comb begin
    nxt_irq            = '0;
    nxt_irq[IRQ_SM0]   = nxt_pend[SRC_SM0];
    nxt_irq[IRQ_SM1]   = nxt_pend[SRC_SM1];
    nxt_irq[IRQ_TW0]   = nxt_pend[SRC_TW0];
    nxt_irq[IRQ_TW1]   = nxt_pend[SRC_TW1];
    nxt_irq[IRQ_RTC]   = nxt_pend[SRC_RTC];
    nxt_irq[IRQ_ITM]   = nxt_pend[SRC_ITM];
    nxt_irq[IRQ_UTM]   = nxt_pend[SRC_UTM];
    nxt_irq[IRQ_PAD]   = |nxt_pend[SRC_PAD +: PAD_NUM];
    nxt_irq[IRQ_BUF]   = |nxt_pend[SRC_BUF +: BUF_NUM];
    nxt_irq[IRQ_FLASH] = nxt_pend[SRC_QD] | nxt_pend[SRC_QF];
    nxt_irq[IRQ_RD]    = |nxt_pend[SRC_RD +: SCRATCH_NUM];
    nxt_irq[IRQ_WR]    = |nxt_pend[SRC_WR +: SCRATCH_NUM];
    nxt_irq[IRQ_SW +: SW_NUM] = nxt_pend[SRC_SW +: SW_NUM];
  end

  // lines 30 and 34 are served elsewhere and stay low here
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      core_irq_ff    <= '0;
      event_class_ff <= '0;
    end else begin
      core_irq_ff    <= nxt_irq;
      event_class_ff <= EVENT_CLASS_MASK;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  AST_RD_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
    host_read_access |=> core_irq_ff[IRQ_RD] && pend_ff[SRC_RD + $past(host_read_sel)])
    else $error("read access did not raise line 35");
  AST_WR_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
    host_write_access |=> core_irq_ff[IRQ_WR] && pend_ff[SRC_WR + $past(host_write_sel)])
    else $error("write access did not raise line 36");
  AST_BUF: assert property (@(posedge clk_sys) disable iff (!rstn)
    (host_chan0_overflow_req || host_chan3_underflow_req) |=> core_irq_ff[IRQ_BUF])
    else $error("buffer error did not raise line 32");
  AST_SM: assert property (@(posedge clk_sys) disable iff (!rstn)
    serial_master1_done_req |=> core_irq_ff[IRQ_SM1] && pend_ff[SRC_SM1])
    else $error("serial master 1 done did not raise line 24");
  AST_TW: assert property (@(posedge clk_sys) disable iff (!rstn)
    twowire_master0_done_req |=> core_irq_ff[IRQ_TW0])
    else $error("two-wire master 0 done did not raise line 25");
  AST_FLASH: assert property (@(posedge clk_sys) disable iff (!rstn)
    core_irq_ff[IRQ_FLASH] == (pend_ff[SRC_QD] || pend_ff[SRC_QF]))
    else $error("line 33 disagrees with flash pending");
  AST_RTC: assert property (@(posedge clk_sys) disable iff (!rstn)
    rtc_overflow_req |=> core_irq_ff[IRQ_RTC])
    else $error("rtc overflow did not raise line 27");
  AST_ITM: assert property (@(posedge clk_sys) disable iff (!rstn)
    itimer_limit_req |=> core_irq_ff[IRQ_ITM])
    else $error("interval timer did not raise line 28");
  AST_UTM: assert property (@(posedge clk_sys) disable iff (!rstn)
    (utimer_src_sel == UTM_CAPTURE && utimer_capture_hit) |=> core_irq_ff[IRQ_UTM])
    else $error("capture did not raise line 29");
  AST_PAD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pad_trig_setup[1:0] == TRIG_RISE && pad_event_req[0] && !pad_prev_ff[0])
      |=> core_irq_ff[IRQ_PAD] && pend_ff[SRC_PAD])
    else $error("pad channel 0 rise did not raise line 31");
  AST_SW: assert property (@(posedge clk_sys) disable iff (!rstn)
    ##1 ((core_irq_ff[IRQ_SW +: SW_NUM] & $past(software_request_vec))
      == $past(software_request_vec)))
    else $error("software bit did not reach its line");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (core_irq_ff[IRQ_RD] && !(|core_clear_vec[SRC_RD +: SCRATCH_NUM])) |=> core_irq_ff[IRQ_RD])
    else $error("line 35 dropped with sources still pending");
  AST_OR: assert property (@(posedge clk_sys) disable iff (!rstn)
    core_irq_ff[IRQ_PAD] == (|pend_ff[SRC_PAD +: PAD_NUM]))
    else $error("line 31 disagrees with pad pending");

  COV_RD: cover property (@(posedge clk_sys) disable iff (!rstn)
    host_read_access ##1 core_irq_ff[IRQ_RD]);
  COV_PAD: cover property (@(posedge clk_sys) disable iff (!rstn)
    $rose(core_irq_ff[IRQ_PAD]));
  COV_UTM: cover property (@(posedge clk_sys) disable iff (!rstn)
    utimer_src_sel == UTM_COMPARE && utimer_compare_hit);
  COV_CLR: cover property (@(posedge clk_sys) disable iff (!rstn)
    $fell(core_irq_ff[IRQ_BUF]));

endmodule : periph_irq_mapper

// [verif/core_irq_model.sv]
// behavioural model of the processor core that services and clears pending sources
`timescale 1ns/10ps
module core_irq_model
  import irq_map_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // interrupt lines seen by the core
  input  wire logic [IRQ_HI:IRQ_LO] core_irq_ff,
  // bench command: bits to clear and service delay
  input  wire logic [SRC_NUM-1:0]   clr_cmd,
  input  wire logic [3:0]           lag,
  // clear strobes back to the mapper
  output logic      [SRC_NUM-1:0]   core_clear_vec
);
  logic [SRC_NUM-1:0] held_ff;
  logic [3:0]         cnt_ff;

  // the core only acts while some line is up, and may take a few cycles to get there
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      held_ff        <= '0;
      cnt_ff         <= '0;
      core_clear_vec <= '0;
    end else begin
      core_clear_vec <= '0;
      if (clr_cmd != '0) begin
        held_ff <= clr_cmd;
        cnt_ff  <= lag;
      end else if (held_ff != '0 && |core_irq_ff) begin
        if (cnt_ff == 4'h0) begin
          core_clear_vec <= held_ff;
          held_ff        <= '0;
        end else begin
          cnt_ff <= cnt_ff - 4'h1;
        end
      end
    end
  end
endmodule : core_irq_model

// [verif/peripheral_irq_mapper_tb.sv]
// self-checking bench of the peripheral interrupt mapper
`timescale 1ns/10ps
module peripheral_irq_mapper_tb;
  import irq_map_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic host_read_access, host_write_access;
  logic [3:0] host_read_sel, host_write_sel;
  logic host_chan0_overflow_req, host_chan1_underflow_req;
  logic host_chan2_underflow_req, host_chan3_underflow_req;
  logic serial_master0_done_req, serial_master1_done_req;
  logic twowire_master0_done_req, twowire_master1_done_req;
  logic flash_data_req, flash_done_req, rtc_overflow_req, itimer_limit_req;
  logic [1:0] utimer_src_sel;
  logic utimer_limit_hit, utimer_compare_hit, utimer_capture_hit;
  logic [PAD_NUM-1:0] pad_event_req;
  logic [2*PAD_NUM-1:0] pad_trig_setup;
  logic [SW_NUM-1:0] software_request_vec;
  logic [SRC_NUM-1:0] core_clear_vec, pend_ff, clr_cmd, e_pend, q[$];
  logic [SRC_NUM-1:0] exp_pend = '0;
  logic [SRC_NUM-1:0] seen = '0;
  logic [IRQ_HI:IRQ_LO] core_irq_ff, event_class_ff;
  logic [3:0] lag;
  int seed = 32'hd25aa5bf;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #2 clk_sys = ~clk_sys;

  periph_irq_mapper u_periph_irq_mapper (
    .clk_sys(clk_sys), .rstn(rstn),
    .host_read_access(host_read_access), .host_read_sel(host_read_sel),
    .host_write_access(host_write_access), .host_write_sel(host_write_sel),
    .host_chan0_overflow_req(host_chan0_overflow_req),
    .host_chan1_underflow_req(host_chan1_underflow_req),
    .host_chan2_underflow_req(host_chan2_underflow_req),
    .host_chan3_underflow_req(host_chan3_underflow_req),
    .serial_master0_done_req(serial_master0_done_req),
    .serial_master1_done_req(serial_master1_done_req),
    .twowire_master0_done_req(twowire_master0_done_req),
    .twowire_master1_done_req(twowire_master1_done_req),
    .flash_data_req(flash_data_req), .flash_done_req(flash_done_req),
    .rtc_overflow_req(rtc_overflow_req), .itimer_limit_req(itimer_limit_req),
    .utimer_src_sel(utimer_src_sel), .utimer_limit_hit(utimer_limit_hit),
    .utimer_compare_hit(utimer_compare_hit), .utimer_capture_hit(utimer_capture_hit),
    .pad_event_req(pad_event_req), .pad_trig_setup(pad_trig_setup),
    .software_request_vec(software_request_vec), .core_clear_vec(core_clear_vec),
    .core_irq_ff(core_irq_ff), .event_class_ff(event_class_ff), .pend_ff(pend_ff));
  core_irq_model u_core_irq_model (.clk_sys(clk_sys), .rstn(rstn), .core_irq_ff(core_irq_ff),
    .clr_cmd(clr_cmd), .lag(lag), .core_clear_vec(core_clear_vec));

  // expected line levels from a pending picture
  function automatic logic [IRQ_HI:IRQ_LO] line_map(input logic [SRC_NUM-1:0] p);
    logic [IRQ_HI:IRQ_LO] m;
    m = '0;
    m[26:23] = {p[39], p[38], p[37], p[36]};
    m[29:27] = {p[44], p[43], p[42]};
    m[31] = |p[56:45];
    m[32] = |p[35:32];
    m[33] = |p[41:40];
    m[35] = |p[15:0];
    m[36] = |p[31:16];
    m[40:37] = p[60:57];
    return m;
  endfunction : line_map

  task automatic chk(input string nm, input logic [SRC_NUM-1:0] e, input logic [SRC_NUM-1:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // note an expected change only when the pending picture really moves
  task automatic note(input logic [SRC_NUM-1:0] nx);
    if (nx !== exp_pend) begin
      exp_pend = nx;
      q.push_back(nx);
    end
  endtask : note

  task automatic idle();
    {host_read_access, host_write_access, host_read_sel, host_write_sel} <= '0;
    {host_chan0_overflow_req, host_chan1_underflow_req, host_chan2_underflow_req} <= '0;
    {host_chan3_underflow_req, serial_master0_done_req, serial_master1_done_req} <= '0;
    {twowire_master0_done_req, twowire_master1_done_req, flash_data_req} <= '0;
    {flash_done_req, rtc_overflow_req, itimer_limit_req, utimer_src_sel} <= '0;
    {utimer_limit_hit, utimer_compare_hit, utimer_capture_hit} <= '0;
    {pad_event_req, software_request_vec} <= '0;
  endtask : idle

  // one-cycle request on source s; um picks the universal timer condition
  task automatic fire(input int s, input int um);
    logic [SRC_NUM-1:0] nx;
    @(posedge clk_sys);
    if (s < 16) {host_read_access, host_read_sel} <= {1'b1, s[3:0]};
    else if (s < 32) {host_write_access, host_write_sel} <= {1'b1, s[3:0]};
    else if (s >= 57) software_request_vec[s-57] <= 1'b1;
    else if (s >= 45) pad_event_req[s-45] <= 1'b1;
    else case (s)
      32: host_chan0_overflow_req <= 1'b1;
      33: host_chan1_underflow_req <= 1'b1;
      34: host_chan2_underflow_req <= 1'b1;
      35: host_chan3_underflow_req <= 1'b1;
      36: serial_master0_done_req <= 1'b1;
      37: serial_master1_done_req <= 1'b1;
      38: twowire_master0_done_req <= 1'b1;
      39: twowire_master1_done_req <= 1'b1;
      40: flash_data_req <= 1'b1;
      41: flash_done_req <= 1'b1;
      42: rtc_overflow_req <= 1'b1;
      43: itimer_limit_req <= 1'b1;
      default: begin
        utimer_src_sel <= (um == 2) ? 2'h3 : um[1:0];
        {utimer_capture_hit, utimer_compare_hit, utimer_limit_hit} <= 3'h1 << um;
      end
    endcase
    @(posedge clk_sys);
    idle();
    nx = exp_pend;
    nx[s] = 1'b1;
    note(nx);
    repeat (2) @(posedge clk_sys);
  endtask : fire

  // ask the core model to clear bits after a random service delay
  task automatic clear(input logic [SRC_NUM-1:0] m);
    int l;
    l = $random(seed) & 3;
    @(posedge clk_sys);
    clr_cmd <= m;
    lag <= l[3:0];
    @(posedge clk_sys);
    clr_cmd <= '0;
    note(exp_pend & ~m);
    repeat (l + 4) @(posedge clk_sys);
  endtask : clear

  // watcher: each movement of the flags must match the oldest note
  always @(negedge clk_sys) begin
    if (rstn && pend_ff !== seen) begin
      seen = pend_ff;
      if (q.size() == 0) chk("unexpected pend", exp_pend, pend_ff);
      else begin
        e_pend = q.pop_front();
        chk("pend", e_pend, pend_ff);
        chk("irq", SRC_NUM'(line_map(e_pend)), SRC_NUM'(core_irq_ff));
      end
    end
  end

  // cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    static int pr[5][2] = '{'{32, 35}, '{40, 41}, '{0, 15}, '{16, 31}, '{45, 56}};
    logic [SRC_NUM-1:0] m;
    clr_cmd = '0;
    lag = '0;
    pad_trig_setup = '0;
    idle();
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("event class", SRC_NUM'(18'h00100), SRC_NUM'(event_class_ff));
    for (int s = 0; s < SRC_NUM; s++) begin
      fire(s, 0);
      clear(exp_pend);
    end
    for (int k = 0; k < 3; k++) begin
      fire(44, k);
      clear(exp_pend);
    end
    // unused select and a hit of the wrong condition raise nothing
    @(posedge clk_sys);
    utimer_src_sel <= 2'h2;
    {utimer_capture_hit, utimer_compare_hit, utimer_limit_hit} <= 3'h7;
    @(posedge clk_sys);
    {utimer_src_sel, utimer_limit_hit} <= '0;
    @(posedge clk_sys);
    idle();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("utimer ignored", exp_pend, pend_ff);
    // combined lines hold while one contributor remains
    for (int g = 0; g < 5; g++) begin
      fire(pr[g][0], 0);
      fire(pr[g][1], 0);
      m = '0;
      m[pr[g][0]] = 1'b1;
      clear(m);
      clear(exp_pend);
    end
    // other trigger modes: channel 1 on falls, 2 on both edges, 3 on high level
    @(posedge clk_sys);
    pad_trig_setup <= 24'h0000b4;
    pad_event_req[3:1] <= 3'h7;
    @(posedge clk_sys);
    m = exp_pend;
    m[SRC_PAD+2] = 1'b1;
    m[SRC_PAD+3] = 1'b1;
    note(m);
    repeat (2) @(posedge clk_sys);
    pad_event_req[3:1] <= 3'h0;
    m[SRC_PAD+1] = 1'b1;
    note(m);
    repeat (3) @(posedge clk_sys);
    pad_trig_setup <= '0;
    clear(exp_pend);
    repeat (30) begin
      fire({$random(seed)} % SRC_NUM, {$random(seed)} % 3);
      if ($random(seed) & 1) clear(exp_pend & SRC_NUM'({$random(seed), $random(seed)}));
    end
    // reset in mid-run wipes every flag
    fire(57, 0);
    fire(36, 0);
    note('0);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    fire(20, 0);
    clear(exp_pend);
    @(negedge clk_sys);
    chk("notes left", '0, SRC_NUM'(q.size()));
    chk("final pend", exp_pend, pend_ff);
    chk("event class again", SRC_NUM'(18'h00100), SRC_NUM'(event_class_ff));
    wrap_up();
  end
endmodule : peripheral_irq_mapper_tb
